// *** src/psei_params.svh ***
// constants for the strap, expanded control and interrupt enable register bank
`ifndef PSEI_PARAMS_SVH
`define PSEI_PARAMS_SVH

`define PSEI_ADDR_W 5
`define PSEI_DATA_W 16
`define PSEI_OFS_STRAP 5'h17
`define PSEI_OFS_EXPCTL 5'h18
`define PSEI_OFS_INTCS 5'h1B

`define PSEI_STRAP_NAND_BIT 5
`define PSEI_STRAP_RMII_BIT 1
`define PSEI_STRAP_MII_BIT 0

`define PSEI_EXP_ENERGY_DETECT_POWERDOWN_OFF_BIT 11
`define PSEI_EXP_RANDLAT_BIT 10
`define PSEI_EXP_PRE_RESTORE_BIT 6
`define PSEI_EXP_RESET 16'h0801

`define PSEI_INT_EN_LSB 8
`define PSEI_INT_EN_RESET 8'h00
`define PSEI_INT_FLAG_RESET 8'h00

`define PSEI_SFD_BYTE 8'hD5

`endif

// *** src/psei_pkg.sv ***
// types for the strap, expanded control and interrupt enable register bank
package psei_pkg;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_PREAMBLE,
      RX_DATA
   } psei_rx_e;

   typedef logic [15:0] psei_word_t;

endpackage

// *** src/psei_bank.sv ***
// strap readback, expanded control and interrupt control/status register bank
`timescale 1ns/100ps
`default_nettype none
`include "psei_params.svh"

module psei_bank #(
   parameter bit IS_RMII = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register access from the management frame logic
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // strap pins, sampled after reset
   input wire logic strapNandTree,
   input wire logic strapRmii,
   input wire logic strapMii,
   // core events and controls
   input wire logic [7:0] eventPulse,
   input wire logic pllOffCtl,
   output logic energyDetectPowerdownEn,
   output logic energyDetectPllOff,
   output logic randomLatencySel,
   output logic intOut,
   // receive byte path toward the MII output
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   input wire logic rxSpeed10,
   output logic [7:0] rxOutByte,
   output logic rxOutValid
);

   // reset release through two flops
   logic rstMeta_reg;
   logic rstSync_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   logic rstN;
   assign rstN = rstSync_reg;

   // strap pins: two-flop sync, then caught once after release
   logic [2:0] strapMeta_reg;
   logic [2:0] strapSync_reg;
   logic [2:0] strapHeld_reg;
   logic [2:0] strapHeld_next;
   logic strapDone_reg;
   logic strapDone_next;

   always_comb begin
      strapHeld_next = strapHeld_reg;
      strapDone_next = 1'b1;
      if (!strapDone_reg) begin
         strapHeld_next = strapSync_reg;
      end
   end

   // sync flops carry no reset so the pins are already through them at release
   always_ff @(posedge clk) begin
      strapMeta_reg <= {strapNandTree, strapRmii, strapMii};
      strapSync_reg <= strapMeta_reg;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         strapHeld_reg <= 3'h0;
         strapDone_reg <= 1'b0;
      end else begin
         strapHeld_reg <= strapHeld_next;
         strapDone_reg <= strapDone_next;
      end
   end

   // register state
   psei_pkg::psei_word_t expCtl_reg;
   psei_pkg::psei_word_t expCtl_next;
   logic [7:0] intEn_reg;
   logic [7:0] intEn_next;
   logic [7:0] intFlag_reg;
   logic [7:0] intFlag_next;
   logic [15:0] rdData_reg;
   logic [15:0] rdData_next;
   logic irq_reg;
   logic irq_next;

   function automatic psei_pkg::psei_word_t strapWord(input logic [2:0] held);
      psei_pkg::psei_word_t w;
      w = 16'h0000; // reserved 4:2 and unmodelled fields read zero
      w[`PSEI_STRAP_NAND_BIT] = held[2];
      w[`PSEI_STRAP_RMII_BIT] = IS_RMII & held[1];
      w[`PSEI_STRAP_MII_BIT] = ~IS_RMII & held[0];
      return w;
   endfunction

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      return a == ofs;
   endfunction

   always_comb begin
      expCtl_next = expCtl_reg;
      intEn_next = intEn_reg;
      intFlag_next = intFlag_reg;
      rdData_next = rdData_reg;
      if (regWr && hit(regAddr, `PSEI_OFS_EXPCTL)) begin
         expCtl_next = regWrData; // all bits writable
      end
      if (regWr && hit(regAddr, `PSEI_OFS_INTCS)) begin
         intEn_next = regWrData[15:`PSEI_INT_EN_LSB];
      end
      if (regRd) begin
         if (hit(regAddr, `PSEI_OFS_STRAP)) begin
            rdData_next = strapWord(strapHeld_reg);
         end else if (hit(regAddr, `PSEI_OFS_EXPCTL)) begin
            rdData_next = expCtl_reg;
         end else if (hit(regAddr, `PSEI_OFS_INTCS)) begin
            rdData_next = {intEn_reg, intFlag_reg};
            intFlag_next = 8'h00;
         end else begin
            rdData_next = 16'h0000;
         end
      end
      // a new event in the read cycle survives the clear
      intFlag_next = intFlag_next | eventPulse;
      // follows the flags so it drops the cycle after the clearing read
      irq_next = |(intFlag_next & intEn_next);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         expCtl_reg <= `PSEI_EXP_RESET;
         intEn_reg <= `PSEI_INT_EN_RESET;
         intFlag_reg <= `PSEI_INT_FLAG_RESET;
         rdData_reg <= 16'h0000;
         irq_reg <= 1'b0;
      end else begin
         expCtl_reg <= expCtl_next;
         intEn_reg <= intEn_next;
         intFlag_reg <= intFlag_next;
         rdData_reg <= rdData_next;
         irq_reg <= irq_next;
      end
   end

   assign regRdData = rdData_reg;
   assign intOut = irq_reg;
   assign energyDetectPowerdownEn = ~expCtl_reg[`PSEI_EXP_ENERGY_DETECT_POWERDOWN_OFF_BIT];
   assign energyDetectPllOff = ~expCtl_reg[`PSEI_EXP_ENERGY_DETECT_POWERDOWN_OFF_BIT] & pllOffCtl;
   // latency choice has no meaning on the reduced-pin variant
   assign randomLatencySel = ~IS_RMII & expCtl_reg[`PSEI_EXP_RANDLAT_BIT];

   // receive path: preamble is dropped only in 10BASE-T without restore
   psei_pkg::psei_rx_e rxState_reg;
   psei_pkg::psei_rx_e rxState_next;
   logic [7:0] rxOut_reg;
   logic [7:0] rxOut_next;
   logic rxOutValid_reg;
   logic rxOutValid_next;
   logic stripPre;

   assign stripPre = rxSpeed10 & ~expCtl_reg[`PSEI_EXP_PRE_RESTORE_BIT];

   always_comb begin
      rxState_next = rxState_reg;
      rxOut_next = rxOut_reg;
      rxOutValid_next = 1'b0;
      unique case (rxState_reg)
         psei_pkg::RX_IDLE, psei_pkg::RX_PREAMBLE: begin
            if (rxValid) begin
               if (rxByte == `PSEI_SFD_BYTE) begin
                  rxState_next = psei_pkg::RX_DATA;
                  rxOut_next = rxByte; // frame starts at SFD
                  rxOutValid_next = 1'b1;
               end else begin
                  rxState_next = psei_pkg::RX_PREAMBLE;
                  rxOut_next = rxByte;
                  rxOutValid_next = ~stripPre;
               end
            end else begin
               rxState_next = psei_pkg::RX_IDLE;
            end
         end
         psei_pkg::RX_DATA: begin
            if (rxValid) begin
               rxOut_next = rxByte;
               rxOutValid_next = 1'b1;
            end else begin
               rxState_next = psei_pkg::RX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rxState_reg <= psei_pkg::RX_IDLE;
         rxOut_reg <= 8'h00;
         rxOutValid_reg <= 1'b0;
      end else begin
         rxState_reg <= rxState_next;
         rxOut_reg <= rxOut_next;
         rxOutValid_reg <= rxOutValid_next;
      end
   end

   assign rxOutByte = rxOut_reg;
   assign rxOutValid = rxOutValid_reg;

endmodule

`default_nettype wire

// *** tb/psei_bank_asserts.sv ***
// port assertions for the register bank
`timescale 1ns/100ps
`default_nettype none
module psei_bank_asserts #(parameter bit IS_RMII = 1'b0) (
   // clock, reset and register strobes
   input wire logic clk, nrst, regWr, regRd,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData, regRdData,
   // core side
   input wire logic [7:0] eventPulse, rxByte, rxOutByte,
   input wire logic pllOffCtl, energyDetectPowerdownEn, energyDetectPllOff, randomLatencySel, intOut,
   input wire logic rxValid, rxSpeed10, rxOutValid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_wexp; regWr && regAddr == 5'h18; endsequence
   sequence s_rexp; regRd && !regWr && regAddr == 5'h18; endsequence
   property p_energy_detect_powerdown; s_wexp |=> energyDetectPowerdownEn == !$past(regWrData[11]); endproperty
   a_energy_detect_powerdown: assert property (p_energy_detect_powerdown) else $error("powerdown enable wrong");
   property p_pll; energyDetectPllOff == (energyDetectPowerdownEn && pllOffCtl); endproperty
   a_pll: assert property (p_pll) else $error("pll off wrong");
   property p_lat; s_wexp |=> randomLatencySel == ($past(regWrData[10]) && !IS_RMII); endproperty
   a_lat: assert property (p_lat) else $error("latency select wrong");
   property p_back; s_wexp ##1 !regWr ##1 s_rexp |=> regRdData == $past(regWrData, 3); endproperty
   a_back: assert property (p_back) else $error("readback wrong");
   property p_strap; regRd && regAddr == 5'h17 |=> regRdData[4:2] == 3'h0; endproperty
   a_strap: assert property (p_strap) else $error("reserved strap bits set");
   property p_clr; regRd && !regWr && regAddr == 5'h1B && eventPulse == 8'h00 |=> !intOut; endproperty
   a_clr: assert property (p_clr) else $error("interrupt kept after read");
   property p_rx; rxValid && !rxSpeed10 |=> rxOutValid && rxOutByte == $past(rxByte); endproperty
   a_rx: assert property (p_rx) else $error("fast byte lost");
   property p_idle; !rxValid |=> !rxOutValid; endproperty
   a_idle: assert property (p_idle) else $error("byte from nowhere");
endmodule
bind psei_bank psei_bank_asserts #(.IS_RMII(IS_RMII)) chk (.*);
`default_nettype wire

// *** tb/psei_smi_model.sv ***
// management controller model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module psei_smi_model (
   input wire logic clk,
   output logic [4:0] regAddr,
   output logic [15:0] regWrData,
   output logic regWr, regRd,
   input wire logic [15:0] regRdData
);
   initial {regAddr, regWrData, regWr, regRd} = '0;
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk);
      {regAddr, regWrData, regWr, regRd} <= {a, d, w, !w};
      @(posedge clk);
      // released bus shows no stale value
      {regAddr, regWrData, regWr, regRd} <= {~a, ~d, 2'b00};
      #1 q = regRdData;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 0, nrst = 0, pllOffCtl = 0, rxValid = 0, rxSpeed10 = 0;
   logic strapNandTree = 1, strapRmii = 0, strapMii = 1;
   logic [7:0] eventPulse = '0, rxByte = '0, rxOutByte, en, b, got[$], want[$];
   logic [4:0] regAddr;
   logic [15:0] regWrData, regRdData, q, d, expExp = 16'h0801;
   logic regWr, regRd, energyDetectPowerdownEn, energyDetectPllOff, randomLatencySel, intOut, rxOutValid;
   int miscompares = 0, compares = 0, seed = 66030;
   initial forever #10 clk = ~clk;
   psei_bank dut (.*);
   psei_smi_model smi (.*);
   always @(posedge clk) if (rxOutValid === 1'b1) got.push_back(rxOutByte);
   task chk(input logic [31:0] g, input logic [31:0] w);
      compares++;
      if (g !== w) begin
         miscompares++;
         $display("wrong value at %0t: got %h want %h", $time, g, w);
      end
   endtask
   task conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [15:0] v);
      smi.acc(1, a, v, q);
      if (a == 5'h18) expExp = v;
   endtask
   // seven preamble bytes, delimiter, three data bytes
   task frame(input logic s10);
      want = {};
      @(posedge clk) rxSpeed10 <= s10;
      got = {};
      for (int i = 0; i < 11; i++) begin
         b = i < 7 ? 8'h55 : i == 7 ? 8'hD5 : 8'($random(seed));
         if (i >= 7 || !s10 || expExp[6]) want.push_back(b);
         @(posedge clk) {rxValid, rxByte} <= {1'b1, b};
      end
      @(posedge clk) rxValid <= 0;
      repeat (2) @(posedge clk);
      chk(16'(got.size()), 16'(want.size()));
      foreach (want[i]) chk(got[i], want[i]);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      repeat (8) @(posedge clk);
      chk(energyDetectPowerdownEn, 0);
      smi.acc(0, 5'h18, 0, q);
      chk(q, 16'h0801);
      smi.acc(0, 5'h1B, 0, q);
      chk(q, 16'h0000);
      smi.acc(0, 5'h05, 0, q);
      chk(q, 16'h0000);
      $display("test reset done");
      repeat (4) begin
         d = 16'($random(seed));
         @(posedge clk) pllOffCtl <= d[4];
         wr(5'h17, d);
         smi.acc(0, 5'h17, 0, q);
         chk(q, 16'h0021);
         wr(5'h18, d);
         smi.acc(0, 5'h18, 0, q);
         chk(q, d);
         chk({randomLatencySel, energyDetectPowerdownEn, energyDetectPllOff}, {d[10], !d[11], !d[11] && d[4]});
      end
      $display("test control done");
      for (int i = 0; i < 8; i++) begin
         en = 8'($random(seed));
         en[i] = i[0];
         wr(5'h1B, {en, 8'($random(seed))});
         @(posedge clk) eventPulse <= 8'h01 << i;
         @(posedge clk) eventPulse <= 0;
         #1 chk(intOut, en[i]);
         smi.acc(0, 5'h1B, 0, q);
         chk({q, intOut}, {en, 8'h01 << i, 1'b0});
         smi.acc(0, 5'h1B, 0, q);
         chk(q, {en, 8'h00});
      end
      $display("test interrupt done");
      @(posedge clk) {nrst, strapNandTree, strapMii} <= 3'b000;
      repeat (6) @(posedge clk);
      nrst <= 1;
      repeat (8) @(posedge clk);
      expExp = 16'h0801;
      smi.acc(0, 5'h17, 0, q);
      chk(q, 16'h0000);
      smi.acc(0, 5'h18, 0, q);
      chk(q, 16'h0801);
      smi.acc(0, 5'h1B, 0, q);
      chk({q, intOut}, 17'h00000);
      $display("test second reset done");
      wr(5'h18, 16'h0801);
      frame(1);
      wr(5'h18, 16'h0841);
      frame(1);
      frame(0);
      $display("test receive done");
      conclude;
   end
   initial begin
      #100000;
      miscompares++;
      conclude;
   end
endmodule
`default_nettype wire
